// ### inc/pdml_defs.svh
// Offsets, field positions, reset values and timing counts of the power-down logic
// Included by the design module pdml_top by bare name
`ifndef PDML_DEFS_SVH
`define PDML_DEFS_SVH
`define PDML_CTRL_OFFSET 12'h000
`define PDML_STATUS_OFFSET 12'h004
`define PDML_CTRL_RESET 32'h00000000
`define PDML_FIELD_LSB 10
`define PDML_FIELD_MSB 15
`define PDML_BIT_GLOBAL_EN 0
`define PDML_BIT_GATE 10
`define PDML_BIT_OUT_STOP 11
`define PDML_BIT_IN_STOP 12
`define PDML_BIT_WAKE_EN 13
`define PDML_BIT_WAKE_ANY 14
`define PDML_ENC_NONE 6'h00
`define PDML_ENC_GATE_EN 6'h09
`define PDML_ENC_GATE_ANY 6'h11
`define PDML_ENC_OUT_STOP 6'h1A
`define PDML_ENC_IN_STOP 6'h1C
`define PDML_ENTRY_CYCLES 4'h8
`define PDML_CNT_W 4
`define PDML_LOCK_TIME_US 75
`define PDML_CLK_MHZ 50
`define PDML_LOCK_MAX_PCT 250
`endif

// ### inc/pdml_pkg.sv
// Types shared by the power-down logic modules
// Constants live in pdml_defs.svh
package pdml_pkg;
	typedef enum logic [2:0] {
		PDML_RUN,
		PDML_ARM,
		PDML_GATED,
		PDML_STOPPED,
		PDML_RELOCK
	} pdml_state_e;
	typedef logic [5:0] pdml_field_t;
endpackage

// ### verilog/pdml_sync.sv
// Two flip-flop synchroniser for a bundle of asynchronous levels
// Assumes each bit is an independent level; no bus coherency across bits
`timescale 1ns/100ps
module pdml_sync #(
	parameter int WIDTH = 1
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Levels
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] stage1;
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			stage1 <= '0;
			sync_out <= '0;
		end
		else
		begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule

// ### verilog/pdml_top.sv
// Power-down mode controller: control/status register on APB, clock gates and PLL stop
// Assumes the interrupt lines, PLL lock and enable bits arrive asynchronously
// Contract
// - Mode field sits in bits 15 to 10
// - Field bits read/write, reset to zero
// - Clock gating starts eight cycles after write
// - 001001 gates CPU, wake on enabled interrupt
// - 010001 gates CPU, wake on any interrupt
// - CPU clock blocked except interrupt logic
// - DMA keeps running while CPU gated
// - Non-enabled wake resumes without service routine
// - Enabled wake runs service routine, then resumes
// - Service routine needs both interrupt enables set
// - 011010 halts PLL output clock tree
// - 011100 stops PLL input clock
// - PLL stop modes leave only by reset
// - Registers and RAM retained while stopped
// - Functional outputs freeze while stopped
// - Async peripherals may still toggle outputs
// - After reset wait for PLL relock
//
// Design decisions made here: the APB slave port and the address map.
`timescale 1ns/100ps
`include "pdml_defs.svh"
module pdml_top #(
	parameter int LOCK_CYCLES = (`PDML_LOCK_TIME_US * `PDML_LOCK_MAX_PCT / 100) * `PDML_CLK_MHZ
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// APB slave
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	// Interrupt sources, nonmaskable enable and PLL lock
	input wire logic int_pending_in,
	input wire logic int_enabled_pending_in,
	input wire logic nonmaskable_int_enable_in,
	input wire logic pll_locked_in,
	// Clock controls, I/O freeze and wake pulses
	output logic cpu_clk_enable_out,
	output logic pll_output_enable_out,
	output logic pll_input_enable_out,
	output logic io_freeze_out,
	output logic service_request_out,
	output logic resume_out,
	output logic dma_clk_enable_out
);
	logic [3:0] sync_q;
	logic int_any;
	logic int_en;
	logic nm_en;
	logic locked;
	logic dma_en, next_dma_en;
	pdml_pkg::pdml_state_e state, next_state;
	pdml_pkg::pdml_field_t power_down_field, next_power_down_field;
	logic global_int_enable, next_global_int_enable;
	logic [`PDML_CNT_W-1:0] entry_cnt, next_entry_cnt;
	logic [31:0] lock_cnt, next_lock_cnt;
	logic [31:0] prdata, next_prdata;
	logic pready, next_pready;
	logic pslverr, next_pslverr;
	logic cpu_en, next_cpu_en;
	logic pll_out_en, next_pll_out_en;
	logic pll_in_en, next_pll_in_en;
	logic freeze, next_freeze;
	logic svc, next_svc;
	logic resume, next_resume;
	logic wr_access;
	logic rd_access;
	pdml_sync #(
		.WIDTH(4)
	) u_sync (
		.clk_in(clk_in),
		.rst_b_in(rst_b_in),
		.async_in({int_pending_in, int_enabled_pending_in, nonmaskable_int_enable_in,
			pll_locked_in}),
		.sync_out(sync_q)
	);
	assign int_any = sync_q[3];
	assign int_en = sync_q[2];
	assign nm_en = sync_q[1];
	assign locked = sync_q[0];
	assign wr_access = psel_in && penable_in && pwrite_in && !pready;
	assign rd_access = psel_in && penable_in && !pwrite_in && !pready;
	always_comb
	begin
		next_pready = psel_in && penable_in && !pready;
		next_pslverr = 1'b0;
		next_prdata = prdata;
		next_power_down_field = power_down_field;
		next_global_int_enable = global_int_enable;
		if (psel_in && penable_in && !pready)
		begin
			if (paddr_in == `PDML_CTRL_OFFSET)
			begin
				if (wr_access && state == pdml_pkg::PDML_RUN)
				begin
					// Whole field latched in one write
					next_power_down_field = pwdata_in[`PDML_FIELD_MSB:`PDML_FIELD_LSB];
					next_global_int_enable = pwdata_in[`PDML_BIT_GLOBAL_EN];
				end
				if (rd_access)
				begin
					next_prdata = 32'h00000000;
					next_prdata[`PDML_FIELD_MSB:`PDML_FIELD_LSB] = power_down_field;
					next_prdata[`PDML_BIT_GLOBAL_EN] = global_int_enable;
				end
			end
			else if (paddr_in == `PDML_STATUS_OFFSET)
			begin
				next_prdata = {26'h0000000, locked, int_any, int_en, 3'(state)};
				next_pslverr = pwrite_in;
			end
			else
			begin
				next_prdata = 32'h00000000;
				next_pslverr = 1'b1;
			end
		end
		// Field clears on wake so the CPU does not re-enter gating
		if (state == pdml_pkg::PDML_GATED && next_state == pdml_pkg::PDML_RUN)
		begin
			next_power_down_field = `PDML_ENC_NONE;
		end
	end
	always_comb
	begin
		next_state = state;
		next_entry_cnt = entry_cnt;
		next_lock_cnt = lock_cnt;
		next_cpu_en = cpu_en;
		next_pll_out_en = pll_out_en;
		next_pll_in_en = pll_in_en;
		next_freeze = freeze;
		next_svc = 1'b0;
		next_resume = 1'b0;
		case (state)
			pdml_pkg::PDML_RELOCK:
			begin
				next_cpu_en = 1'b0;
				if (locked || lock_cnt == 32'h00000000)
				begin
					next_state = pdml_pkg::PDML_RUN;
					next_cpu_en = 1'b1;
				end
				else
				begin
					next_lock_cnt = lock_cnt - 32'h00000001;
				end
			end
			pdml_pkg::PDML_RUN:
			begin
				if (power_down_field == `PDML_ENC_OUT_STOP ||
					power_down_field == `PDML_ENC_IN_STOP)
				begin
					next_state = pdml_pkg::PDML_STOPPED;
					next_freeze = 1'b1;
					next_cpu_en = 1'b0;
					// Bits 11 and 12 pick the stop point
					next_pll_out_en = !power_down_field[`PDML_BIT_OUT_STOP - `PDML_FIELD_LSB];
					next_pll_in_en = !power_down_field[`PDML_BIT_IN_STOP - `PDML_FIELD_LSB];
				end
				else if (power_down_field == `PDML_ENC_GATE_EN ||
					power_down_field == `PDML_ENC_GATE_ANY)
				begin
					next_state = pdml_pkg::PDML_ARM;
					next_entry_cnt = `PDML_ENTRY_CYCLES - 4'h1;
				end
			end
			pdml_pkg::PDML_ARM:
			begin
				if (entry_cnt == 4'h1)
				begin
					next_state = pdml_pkg::PDML_GATED;
					next_cpu_en = 1'b0;
				end
				next_entry_cnt = entry_cnt - 4'h1;
			end
			pdml_pkg::PDML_GATED:
			begin
				if (int_en || (int_any && power_down_field[`PDML_BIT_WAKE_ANY - `PDML_FIELD_LSB]))
				begin
					next_state = pdml_pkg::PDML_RUN;
					next_cpu_en = 1'b1;
					if (int_en && global_int_enable && nm_en)
					begin
						next_svc = 1'b1;
					end
					else
					begin
						next_resume = 1'b1;
					end
				end
			end
			pdml_pkg::PDML_STOPPED:
			begin
				next_state = pdml_pkg::PDML_STOPPED;
			end
			default:
			begin
				next_state = pdml_pkg::PDML_RUN;
			end
		endcase
		// DMA clock follows the PLL path, not the CPU gate
		next_dma_en = next_pll_out_en && next_pll_in_en;
	end
	always_ff @(posedge clk_in or negedge rst_b_in)
	begin
		if (!rst_b_in)
		begin
			state <= pdml_pkg::PDML_RELOCK;
			power_down_field <= `PDML_ENC_NONE;
			global_int_enable <= 1'b0;
			entry_cnt <= 4'h0;
			lock_cnt <= 32'(LOCK_CYCLES);
			prdata <= `PDML_CTRL_RESET;
			dma_en <= 1'b1;
			pready <= 1'b0;
			pslverr <= 1'b0;
			cpu_en <= 1'b0;
			pll_out_en <= 1'b1;
			pll_in_en <= 1'b1;
			freeze <= 1'b0;
			svc <= 1'b0;
			resume <= 1'b0;
		end
		else
		begin
			state <= next_state;
			power_down_field <= next_power_down_field;
			global_int_enable <= next_global_int_enable;
			entry_cnt <= next_entry_cnt;
			lock_cnt <= next_lock_cnt;
			prdata <= next_prdata;
			dma_en <= next_dma_en;
			pready <= next_pready;
			pslverr <= next_pslverr;
			cpu_en <= next_cpu_en;
			pll_out_en <= next_pll_out_en;
			pll_in_en <= next_pll_in_en;
			freeze <= next_freeze;
			svc <= next_svc;
			resume <= next_resume;
		end
	end
	// Registered so the output comes straight from a flop
	assign dma_clk_enable_out = dma_en;
	assign prdata_out = prdata;
	assign pready_out = pready;
	assign pslverr_out = pslverr;
	assign cpu_clk_enable_out = cpu_en;
	assign pll_output_enable_out = pll_out_en;
	assign pll_input_enable_out = pll_in_en;
	assign io_freeze_out = freeze;
	assign service_request_out = svc;
	assign resume_out = resume;
endmodule

// ### verif/pdml_props.sv
// Port checker for the power-down controller
// Assumes one clock domain; bound onto pdml_top
`timescale 1ns/100ps
module pdml_props (
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_b_in,
	// Bus
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [11:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	input wire logic pready_out,
	// Controls
	input wire logic nonmaskable_int_enable_in,
	input wire logic cpu_clk_enable_out,
	input wire logic pll_output_enable_out,
	input wire logic pll_input_enable_out,
	input wire logic io_freeze_out,
	input wire logic service_request_out,
	input wire logic resume_out,
	input wire logic dma_clk_enable_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!rst_b_in);
	logic acc;
	logic [5:0] fld;
	logic cpu;
	assign acc = psel_in && penable_in && pwrite_in && pready_out && paddr_in == 12'h000;
	assign fld = pwdata_in[15:10];
	assign cpu = cpu_clk_enable_out;
	a_gate_delay: assert property (acc && cpu && (fld == 6'h09 || fld == 6'h11)
		|-> cpu [*5] ##[1:4] !cpu) else $error("gating late or early");
	a_pd2_stop: assert property (acc && cpu && fld == 6'h1A
		|-> ##[1:3] !pll_output_enable_out && io_freeze_out) else $error("no output stop");
	a_pd3_stop: assert property (acc && cpu && fld == 6'h1C
		|-> ##[1:3] !pll_input_enable_out && io_freeze_out) else $error("no input stop");
	a_stop_sticky: assert property (!pll_output_enable_out || !pll_input_enable_out
		|=> $stable({pll_output_enable_out, pll_input_enable_out})) else $error("stop left");
	a_freeze_quiet: assert property (io_freeze_out
		|-> !cpu && !service_request_out && !resume_out) else $error("woke from stop");
	a_dma_runs: assert property (!cpu && pll_output_enable_out && pll_input_enable_out
		|-> dma_clk_enable_out) else $error("dma stopped");
	a_wake_pulse: assert property (service_request_out || resume_out
		|-> cpu && !(service_request_out && resume_out)) else $error("bad wake pulse");
	a_svc_enables: assert property (service_request_out
		|-> nonmaskable_int_enable_in) else $error("service without enable");
	c_gate: cover property ($fell(cpu));
	c_svc: cover property (service_request_out);
	c_stop: cover property (io_freeze_out);
endmodule
bind pdml_top pdml_props u_pdml_props (.clk_in(clk_in), .rst_b_in(rst_b_in),
	.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
	.paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
	.nonmaskable_int_enable_in(nonmaskable_int_enable_in),
	.cpu_clk_enable_out(cpu_clk_enable_out), .pll_output_enable_out(pll_output_enable_out),
	.pll_input_enable_out(pll_input_enable_out), .io_freeze_out(io_freeze_out),
	.service_request_out(service_request_out), .resume_out(resume_out),
	.dma_clk_enable_out(dma_clk_enable_out));

// ### verif/tb_power_down_mode_logic.sv
// Bench: APB register access, CPU gating with wake, PLL stops ended by reset
// Assumes pdml_top with a short relock count
`timescale 1ns/100ps
module tb_power_down_mode_logic;
	logic clk_in = 1'b0;
	logic rst_b_in = 1'b0;
	logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
	logic [11:0] paddr_in = 12'h000;
	logic [31:0] pwdata_in = 32'h00000000, prdata_out, rd;
	logic pready_out, pslverr_out, err, svc, res;
	logic int_pending_in = 1'b0, int_enabled_pending_in = 1'b0;
	logic nonmaskable_int_enable_in = 1'b0, pll_locked_in = 1'b1;
	logic cpu, pll_out, pll_in, frz, service_request_out, resume_out, dma;
	logic [31:0] seed = 32'h0000FCE4;
	// Entries: field, global enable, nonmaskable enable, enabled interrupt
	logic [8:0] wk [5] = '{9'h04F, 9'h08A, 9'h04B, 9'h04D, 9'h08F};
	int n_errors = 0, samples_checked = 0, n;
	int exp_q[$];
	initial forever #10 clk_in = ~clk_in;
	pdml_top #(.LOCK_CYCLES(20)) u_pdml_top (.clk_in(clk_in), .rst_b_in(rst_b_in),
		.psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in),
		.paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .int_pending_in(int_pending_in),
		.int_enabled_pending_in(int_enabled_pending_in), .pll_locked_in(pll_locked_in),
		.nonmaskable_int_enable_in(nonmaskable_int_enable_in), .cpu_clk_enable_out(cpu),
		.pll_output_enable_out(pll_out), .pll_input_enable_out(pll_in), .io_freeze_out(frz),
		.service_request_out(service_request_out), .resume_out(resume_out),
		.dma_clk_enable_out(dma));
	function logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task finish_test();
		$display("errors %0d checks %0d", n_errors, samples_checked);
		if (n_errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task hang();
		chk(32'h0, 32'h1);
		finish_test();
	endtask
	// Waiting on a released bus would hang the run, so every wait is bounded
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		psel_in <= 1'b1;
		penable_in <= 1'b0;
		pwrite_in <= w;
		paddr_in <= a;
		pwdata_in <= d;
		@(posedge clk_in);
		penable_in <= 1'b1;
		// Values read here are those sampled at this rising edge
		repeat (20)
		begin
			@(posedge clk_in);
			if (pready_out === 1'b1)
				break;
		end
		if (pready_out !== 1'b1)
			hang();
		rd = prdata_out;
		err = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task wait_en(input logic lvl);
		svc = 1'b0;
		res = 1'b0;
		for (n = 1; n < 40; n++)
		begin
			@(negedge clk_in);
			svc |= service_request_out;
			res |= resume_out;
			if (cpu === lvl)
				break;
		end
		if (cpu !== lvl)
			hang();
	endtask
	task do_reset();
		rst_b_in <= 1'b0;
		repeat (20) @(posedge clk_in);
		rst_b_in <= 1'b1;
	endtask
	initial
	begin
		int k;
		logic [31:0] d;
		do_reset();
		wait_en(1'b1);
		apb(1'b0, 12'h000, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 12'h008, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		apb(1'b1, 12'h004, 32'h0);
		chk({31'h0, err}, 32'h1);
		for (k = 0; k < 4; k++)
		begin
			d = xs() & 32'hFFFF7FFF;
			if (d[15:10] inside {6'h09, 6'h11, 6'h1A, 6'h1C})
				d[10] = ~d[10];
			apb(1'b1, 12'h000, d);
			exp_q.push_back(d & 32'h0000FC01);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, exp_q.pop_front());
			repeat (12) @(negedge clk_in);
			chk({31'h0, cpu}, 32'h1);
		end
		@(posedge clk_in);
		for (k = 0; k < 5; k++)
		begin
			nonmaskable_int_enable_in <= wk[k][1];
			apb(1'b1, 12'h000, {16'h0, wk[k][8:3], 9'h0, wk[k][2]});
			wait_en(1'b0);
			chk({31'h0, n >= 5 && n <= 9}, 32'h1);
			@(posedge clk_in);
			// Any-wake entries with an enabled source see both lines together
			int_pending_in <= 1'b1;
			int_enabled_pending_in <= wk[k][0] && wk[k][8:3] == 6'h11;
			svc = 1'b0;
			res = 1'b0;
			repeat (10)
			begin
				@(negedge clk_in);
				svc |= service_request_out;
				res |= resume_out;
			end
			chk({31'h0, cpu}, {31'h0, wk[k][8:3] == 6'h11});
			if (cpu !== 1'b1)
			begin
				@(posedge clk_in);
				int_enabled_pending_in <= wk[k][0];
				wait_en(1'b1);
			end
			d = wk[k][0] & wk[k][2] & wk[k][1];
			chk({30'h0, svc, res}, d[0] ? 32'h2 : 32'h1);
			@(posedge clk_in);
			int_pending_in <= 1'b0;
			int_enabled_pending_in <= 1'b0;
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, {31'h0, wk[k][2]});
		end
		for (k = 0; k < 2; k++)
		begin
			apb(1'b1, 12'h000, k ? 32'h00007000 : 32'h00006800);
			int_pending_in <= 1'b1;
			int_enabled_pending_in <= 1'b1;
			repeat (12) @(negedge clk_in);
			chk({cpu, pll_out, pll_in, frz, dma}, k ? 32'hA : 32'h6);
			@(posedge clk_in);
			int_pending_in <= 1'b0;
			int_enabled_pending_in <= 1'b0;
			pll_locked_in <= (k == 0);
			do_reset();
			repeat (10) @(negedge clk_in);
			chk({31'h0, cpu}, {31'h0, k == 0});
			wait_en(1'b1);
			apb(1'b0, 12'h000, 32'h0);
			chk(rd, 32'h0);
		end
		finish_test();
	end
endmodule
